// [design/fpc_pkg.sv]
// Overview of operation
// R1: Low program supply fails program/erase, flag bit 3
// R2: Chip select low, reset high means active
// R3: Idle read keeps outputs valid until next read
// R4: Chip select high in read gives standby, float
// R5: Deselect during program/erase lets operation finish
// R6: Reset/power-down low enters deep power-down, floats
// R7: Wait recovery time after power-down before reads
// R8: Power-down during program/erase aborts, data undefined
// R9: Power-down or power loss clears status register
// R10: Either supply first; ramps block program/erase
// R11: Write only with write enable, select low
// R12: Array changes only after two-step command
// R13: Power-down low ignores every other control input
// R14: Latched command survives supply, select, sequencer changes
// R15: Read-array mode after power-up, reset, supply rise
// R16: Issue read-array after program/erase before array reads
// R17: Tie reset/power-down to processor reset
// R18: Check ready bit 7 before error bits
// R19: Lock input low fails lockable block changes
`default_nettype none

package fpc_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int PD_RECOVERY_NS = 150;
   localparam int PD_RECOVERY_CYC = (PD_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_NS = 100;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = 2;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_ADDR1 = 5'h04;
   localparam logic [4:0] OFS_ADDR2 = 5'h08;
   localparam logic [4:0] OFS_WDATA = 5'h0C;
   localparam logic [4:0] OFS_GO = 5'h10;
   localparam logic [4:0] OFS_STATUS = 5'h14;
   localparam logic [4:0] OFS_RDATA = 5'h18;

   // ----------------------------------------
   // Control fields and reset value
   // ----------------------------------------
   localparam int CTRL_PDOWN_BIT = 0;
   localparam int CTRL_UNLOCK_BIT = 1;
   localparam int CTRL_VPP_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // ----------------------------------------
   // Operation codes written to the go register
   // ----------------------------------------
   localparam logic [2:0] OP_READ = 3'h1;
   localparam logic [2:0] OP_CMD = 3'h2;
   localparam logic [2:0] OP_SEQ = 3'h3;
   localparam logic [2:0] OP_STATUS = 3'h4;

   // ----------------------------------------
   // Device status bits
   // ----------------------------------------
   localparam int SR_READY_BIT = 7;
   localparam int SR_ERASE_ERR_BIT = 5;
   localparam int SR_PROG_ERR_BIT = 4;
   localparam int SR_VPP_LOW_BIT = 3;
   localparam int SR_LOCK_BIT = 1;
   localparam logic [7:0] SR_RESET = 8'h00;

   // ----------------------------------------
   // Controller status word fields
   // ----------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_RECOVER = 1;
   localparam int ST_ARRAY = 2;
   localparam int ST_SR_READY = 3;
   localparam int ST_VPP_LOW = 4;
   localparam int ST_LOCK_ERR = 5;
   localparam int ST_PROG_ERR = 6;
   localparam int ST_ERASE_ERR = 7;
   localparam int ST_ABORT = 8;
   localparam int ST_PDOWN = 9;

   // ----------------------------------------
   // Engine states
   // ----------------------------------------
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_PDOWN = 6'b000010,
      S_RECOVER = 6'b000100,
      S_SETUP = 6'b001000,
      S_STROBE = 6'b010000,
      S_GAP = 6'b100000
   } fpc_state_t;

endpackage

`default_nettype wire

// [design/fpc_sync.sv]
`default_nettype none

// Two-stage synchroniser for pin inputs
module fpc_sync #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

`default_nettype wire

// [design/fpc_flash_host.sv]
`default_nettype none

module fpc_flash_host #(
   parameter int ADDR_W = 22,
   parameter int DATA_W = 16,
   parameter logic [15:0] READ_ARRAY_CMD = 16'h00FF,
   parameter int PD_RECOVERY_CYCLES = fpc_pkg::PD_RECOVERY_CYC,
   parameter int ACCESS_CYCLES = fpc_pkg::ACCESS_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [ADDR_W-1:0] flash_addr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_reset_powerdown_n,
   output logic flash_wp_n,
   output logic flash_vpp_en,
   input wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe_n
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Byte-lane merge for register writes
   function automatic logic [31:0] fpc_be_merge(input logic [31:0] old_val,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   localparam logic [7:0] RECOVER_LAST = 8'(PD_RECOVERY_CYCLES - 1);
   localparam logic [7:0] ACCESS_LAST = 8'(ACCESS_CYCLES - 1);
   localparam logic [7:0] GAP_LAST = 8'(fpc_pkg::GAP_CYC - 1);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [DATA_W-1:0] dq_sync;
   logic [2:0] ctrl, next_ctrl;
   logic [ADDR_W-1:0] addr1, next_addr1, addr2, next_addr2;
   logic [31:0] wdata, next_wdata;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic go;
   logic [2:0] go_op;

   fpc_pkg::fpc_state_t state, next_state;
   logic [7:0] cnt, next_cnt;
   logic [2:0] op, next_op;
   logic pre, next_pre, second, next_second;
   logic array_mode, next_array_mode;
   logic aborted, next_aborted;
   logic cur_we, next_cur_we;
   logic [7:0] sr, next_sr;
   logic [DATA_W-1:0] rdata, next_rdata;
   logic [ADDR_W-1:0] next_flash_addr;
   logic next_ce_n, next_oe_n, next_we_n, next_rp_n, next_wp_n, next_vpp_en;
   logic [DATA_W-1:0] next_dq_out;
   logic next_dq_oe_n;
   logic [31:0] status_word;

   // Read data from the pins is asynchronous to core_clk
   fpc_sync #(
      .WIDTH(DATA_W)
   ) u_dq_sync (
      .core_clk(core_clk),
      .srst(srst),
      .d(flash_dq_in),
      .q(dq_sync)
   );

   // ----------------------------------------
   // Status word
   // ----------------------------------------

   // Error bits only mean something once the sequencer says ready
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[fpc_pkg::ST_BUSY] = (state != fpc_pkg::S_IDLE);
      status_word[fpc_pkg::ST_RECOVER] = (state == fpc_pkg::S_RECOVER);
      status_word[fpc_pkg::ST_ARRAY] = array_mode;
      status_word[fpc_pkg::ST_SR_READY] = sr[fpc_pkg::SR_READY_BIT];
      status_word[fpc_pkg::ST_VPP_LOW] = sr[fpc_pkg::SR_READY_BIT] & sr[fpc_pkg::SR_VPP_LOW_BIT]; // R18 R1
      status_word[fpc_pkg::ST_LOCK_ERR] = sr[fpc_pkg::SR_READY_BIT] & sr[fpc_pkg::SR_LOCK_BIT]; // R19
      status_word[fpc_pkg::ST_PROG_ERR] = sr[fpc_pkg::SR_READY_BIT] & sr[fpc_pkg::SR_PROG_ERR_BIT];
      status_word[fpc_pkg::ST_ERASE_ERR] = sr[fpc_pkg::SR_READY_BIT] & sr[fpc_pkg::SR_ERASE_ERR_BIT];
      status_word[fpc_pkg::ST_ABORT] = aborted;
      status_word[fpc_pkg::ST_PDOWN] = (state == fpc_pkg::S_PDOWN);
   end

   // ----------------------------------------
   // Avalon-MM slave
   // ----------------------------------------

   // One wait cycle per access; effect lands on the edge with waitrequest low
   always_comb begin
      logic [31:0] tmp;
      tmp = 32'h0000_0000;
      next_ctrl = ctrl;
      next_addr1 = addr1;
      next_addr2 = addr2;
      next_wdata = wdata;
      next_readdata = avs_readdata;
      next_waitrequest = 1'b1;
      go = 1'b0;
      go_op = avs_writedata[2:0];
      if ((avs_read || avs_write) && avs_waitrequest) begin
         next_waitrequest = 1'b0;
         next_readdata = 32'h0000_0000;
         if (avs_read) begin
            case (avs_address)
               fpc_pkg::OFS_CTRL: next_readdata = {29'h0000_0000, ctrl};
               fpc_pkg::OFS_ADDR1: next_readdata = 32'(addr1);
               fpc_pkg::OFS_ADDR2: next_readdata = 32'(addr2);
               fpc_pkg::OFS_WDATA: next_readdata = wdata;
               fpc_pkg::OFS_STATUS: next_readdata = status_word;
               fpc_pkg::OFS_RDATA: next_readdata = 32'(rdata);
               default: next_readdata = 32'h0000_0000;
            endcase
         end
      end
      if (avs_write && !avs_waitrequest) begin
         case (avs_address)
            fpc_pkg::OFS_CTRL: begin
               tmp = fpc_be_merge({29'h0000_0000, ctrl}, avs_writedata, avs_byteenable);
               next_ctrl = tmp[2:0];
            end
            fpc_pkg::OFS_ADDR1: begin
               tmp = fpc_be_merge(32'(addr1), avs_writedata, avs_byteenable);
               next_addr1 = tmp[ADDR_W-1:0];
            end
            fpc_pkg::OFS_ADDR2: begin
               tmp = fpc_be_merge(32'(addr2), avs_writedata, avs_byteenable);
               next_addr2 = tmp[ADDR_W-1:0];
            end
            fpc_pkg::OFS_WDATA: next_wdata = fpc_be_merge(wdata, avs_writedata, avs_byteenable);
            fpc_pkg::OFS_GO: go = avs_byteenable[0];
            default: tmp = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl <= fpc_pkg::CTRL_RESET; // R10
         addr1 <= '0;
         addr2 <= '0;
         wdata <= 32'h0000_0000;
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         addr1 <= next_addr1;
         addr2 <= next_addr2;
         wdata <= next_wdata;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
      end
   end

   // ----------------------------------------
   // Flash bus engine
   // ----------------------------------------

   // Sequencer of bus cycles, power-down and recovery
   always_comb begin
      logic launch;
      logic launch_we;
      logic [ADDR_W-1:0] launch_addr;
      logic [DATA_W-1:0] launch_data;
      launch = 1'b0;
      launch_we = 1'b0;
      launch_addr = addr1;
      launch_data = wdata[DATA_W-1:0];
      next_state = state;
      next_cnt = cnt;
      next_op = op;
      next_pre = pre;
      next_second = second;
      next_array_mode = array_mode;
      next_aborted = aborted;
      next_cur_we = cur_we;
      next_sr = sr;
      next_rdata = rdata;
      next_flash_addr = flash_addr;
      next_ce_n = flash_ce_n;
      next_oe_n = flash_oe_n;
      next_we_n = flash_we_n;
      next_rp_n = flash_reset_powerdown_n;
      next_dq_out = flash_dq_out;
      next_dq_oe_n = flash_dq_oe_n;
      next_wp_n = ctrl[fpc_pkg::CTRL_UNLOCK_BIT]; // R19
      next_vpp_en = ctrl[fpc_pkg::CTRL_VPP_BIT]; // R1
      case (state)
         fpc_pkg::S_PDOWN: begin
            // Strobes and data drivers held inactive while in power-down; write protect and program supply still follow ctrl
            next_ce_n = 1'b1; // R13
            next_oe_n = 1'b1;
            next_we_n = 1'b1;
            next_dq_oe_n = 1'b1;
            if (!ctrl[fpc_pkg::CTRL_PDOWN_BIT]) begin
               next_rp_n = 1'b1;
               next_cnt = 8'h00;
               next_state = fpc_pkg::S_RECOVER;
            end
         end
         fpc_pkg::S_RECOVER: begin
            next_cnt = cnt + 8'h01;
            if (ctrl[fpc_pkg::CTRL_PDOWN_BIT]) begin
               next_rp_n = 1'b0;
               next_state = fpc_pkg::S_PDOWN;
            end else if (cnt == RECOVER_LAST) begin
               next_array_mode = 1'b1; // R15
               next_state = fpc_pkg::S_IDLE; // R7
            end
         end
         fpc_pkg::S_IDLE: begin
            // Deselected between cycles: standby, outputs floated
            next_ce_n = 1'b1; // R4
            if (ctrl[fpc_pkg::CTRL_PDOWN_BIT]) begin
               next_rp_n = 1'b0; // R6
               next_sr = fpc_pkg::SR_RESET; // R9
               next_state = fpc_pkg::S_PDOWN;
            end else if (go && (go_op == fpc_pkg::OP_READ || go_op == fpc_pkg::OP_CMD ||
                                go_op == fpc_pkg::OP_SEQ || go_op == fpc_pkg::OP_STATUS)) begin
               next_op = go_op;
               next_aborted = 1'b0;
               next_second = 1'b0;
               next_pre = 1'b0;
               launch = 1'b1;
               launch_we = (go_op == fpc_pkg::OP_CMD) || (go_op == fpc_pkg::OP_SEQ);
               if (go_op == fpc_pkg::OP_READ && !array_mode) begin
                  // Status mode still active: restore array reads first
                  next_pre = 1'b1; // R16
                  launch_we = 1'b1;
                  launch_data = READ_ARRAY_CMD[DATA_W-1:0];
               end
            end
         end
         fpc_pkg::S_SETUP: begin
            // Address and select settle one cycle before the strobe
            next_we_n = !cur_we; // R11
            next_oe_n = cur_we;
            next_cnt = 8'h00;
            next_state = fpc_pkg::S_STROBE;
         end
         fpc_pkg::S_STROBE: begin
            next_cnt = cnt + 8'h01;
            if (cnt == ACCESS_LAST) begin
               next_we_n = 1'b1;
               next_oe_n = 1'b1;
               next_ce_n = 1'b1;
               next_cnt = 8'h00;
               next_state = fpc_pkg::S_GAP;
               if (!cur_we && op == fpc_pkg::OP_STATUS) begin
                  next_sr = dq_sync[7:0]; // R18
               end else if (!cur_we) begin
                  next_rdata = dq_sync;
               end
            end
         end
         fpc_pkg::S_GAP: begin
            // Data held past the write strobe, then released
            next_dq_oe_n = 1'b1;
            next_cnt = cnt + 8'h01;
            if (cnt == GAP_LAST) begin
               next_state = fpc_pkg::S_IDLE;
               if (pre) begin
                  next_pre = 1'b0;
                  next_array_mode = 1'b1;
                  launch = 1'b1;
               end else if (op == fpc_pkg::OP_SEQ && !second) begin
                  // Second half of the two-step sequence
                  next_second = 1'b1; // R12
                  next_array_mode = 1'b0; // R16
                  launch = 1'b1;
                  launch_we = 1'b1;
                  launch_addr = addr2;
                  launch_data = wdata[31 -: DATA_W];
               end else if (op == fpc_pkg::OP_CMD) begin
                  next_array_mode = (wdata[DATA_W-1:0] == READ_ARRAY_CMD[DATA_W-1:0]);
               end
            end
         end
         default: begin
            next_state = fpc_pkg::S_PDOWN;
            next_rp_n = 1'b0;
         end
      endcase
      if (launch) begin
         // Select low with reset high puts the part in active mode
         next_cur_we = launch_we;
         next_flash_addr = launch_addr;
         next_ce_n = 1'b0; // R2
         next_dq_out = launch_data;
         next_dq_oe_n = !launch_we;
         next_cnt = 8'h00;
         next_state = fpc_pkg::S_SETUP;
      end
      if (ctrl[fpc_pkg::CTRL_PDOWN_BIT] && (state == fpc_pkg::S_SETUP ||
          state == fpc_pkg::S_STROBE || state == fpc_pkg::S_GAP)) begin
         // Power-down mid-cycle aborts; data of that write is suspect
         next_aborted = cur_we || pre || (op == fpc_pkg::OP_SEQ); // R8
         next_rp_n = 1'b0;
         next_ce_n = 1'b1;
         next_oe_n = 1'b1;
         next_we_n = 1'b1;
         next_dq_oe_n = 1'b1;
         next_sr = fpc_pkg::SR_RESET; // R9
         next_state = fpc_pkg::S_PDOWN;
      end
   end

   // Reset holds the flash in power-down alongside the controller
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= fpc_pkg::S_PDOWN;
         cnt <= 8'h00;
         op <= 3'h0;
         pre <= 1'b0;
         second <= 1'b0;
         array_mode <= 1'b1;
         aborted <= 1'b0;
         cur_we <= 1'b0;
         sr <= fpc_pkg::SR_RESET;
         rdata <= '0;
         flash_addr <= '0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_reset_powerdown_n <= 1'b0; // R17
         flash_wp_n <= 1'b0;
         flash_vpp_en <= 1'b0;
         flash_dq_out <= '0;
         flash_dq_oe_n <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         op <= next_op;
         pre <= next_pre;
         second <= next_second;
         array_mode <= next_array_mode;
         aborted <= next_aborted;
         cur_we <= next_cur_we;
         sr <= next_sr;
         rdata <= next_rdata;
         flash_addr <= next_flash_addr;
         flash_ce_n <= next_ce_n;
         flash_oe_n <= next_oe_n;
         flash_we_n <= next_we_n;
         flash_reset_powerdown_n <= next_rp_n;
         flash_wp_n <= next_wp_n;
         flash_vpp_en <= next_vpp_en;
         flash_dq_out <= next_dq_out;
         flash_dq_oe_n <= next_dq_oe_n;
      end
   end

endmodule

`default_nettype wire

// [testbench/fpc_flash_host_sva.sv]
`default_nettype none

module fpc_flash_host_sva #(
   parameter int PD_RECOVERY_CYCLES = 2
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_reset_powerdown_n,
   input wire logic flash_dq_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   // ------------------------------
   // Cycles awake since power-down
   // ------------------------------
   logic [7:0] awake;
   logic [7:0] next_awake;

   // Saturates so long idle spans never wrap back under the limit
   always_comb begin
      next_awake = awake;
      if (srst || !flash_reset_powerdown_n) begin
         next_awake = 8'h00;
      end else if (awake != 8'hFF) begin
         next_awake = awake + 8'h01;
      end
   end

   // Register only
   always_ff @(posedge core_clk) begin
      awake <= next_awake;
   end

   // ------------------------------
   // Properties
   // ------------------------------
   chk_reset_sleep: assert property (disable iff (1'b0)
      srst |=> !flash_reset_powerdown_n) else $error("reset left flash awake");
   chk_recover_wait: assert property (!flash_oe_n |-> awake >= PD_RECOVERY_CYCLES)
      else $error("read before recovery");
   chk_sleep_quiet: assert property (!flash_reset_powerdown_n |->
      flash_ce_n && flash_oe_n && flash_we_n) else $error("strobe in power-down");
   chk_write_select: assert property (!flash_we_n |->
      !flash_ce_n && flash_oe_n && !flash_dq_oe_n) else $error("bad write strobe");
   chk_read_float: assert property (!flash_oe_n |-> !flash_ce_n && flash_dq_oe_n)
      else $error("bad read strobe");
   chk_we_setup: assert property ($fell(flash_we_n) |->
      $past(flash_ce_n) == 1'b0 && $past(flash_dq_oe_n) == 1'b0) else $error("no setup");
   chk_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("ack longer than one cycle");
   chk_ready_gate: assert property (avs_read && !avs_waitrequest &&
      avs_address == fpc_pkg::OFS_STATUS && !avs_readdata[fpc_pkg::ST_SR_READY]
      |-> avs_readdata[7:4] == 4'h0) else $error("error bits while busy");
endmodule

`default_nettype wire

// [testbench/fpc_flash_model.sv]
`default_nettype none

// Behavioural part; the clock samples its strobes and paces its timers
module fpc_flash_model #(
   parameter int BUSY_CYC = 60,
   parameter int REC_CYC = 2,
   parameter logic [15:0] PROG_CMD = 16'h0040,
   parameter logic [15:0] STAT_CMD = 16'h0070,
   parameter logic [15:0] READ_CMD = 16'h00FF
) (
   input wire logic clk,
   input wire logic [21:0] addr,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_powerdown_n,
   input wire logic wp_n,
   input wire logic vpp_en,
   input wire logic [15:0] dq_wr,
   output logic [15:0] dq_rd
);
   logic [15:0] mem [16];
   logic [15:0] junk = 16'h5A5A;
   logic [15:0] wdat;
   logic [15:0] pd;
   logic [3:0] wa;
   logic [3:0] pa;
   logic [7:0] sr = 8'h80;
   logic [1:0] mode = 2'h0;
   logic wact = 1'b0;
   logic on;
   int busy = 0;
   int rec = 0;

   // Known preload
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'h1000 + 16'(i);
      end
   end

   // Released bus toggles, so a stale value never looks valid
   assign on = reset_powerdown_n & ~ce_n & ~oe_n & (rec >= REC_CYC);
   assign dq_rd = on ? (mode == 2'h0 ? mem[addr[3:0]] : {8'h00, sr}) : junk;

   // Write latch on rising strobe, sequencer timer, power-down
   always @(posedge clk) begin
      junk <= ~dq_rd;
      if (!reset_powerdown_n) begin
         if (busy != 0) mem[pa] <= ~pd;
         busy <= 0;
         sr <= 8'h00;
         mode <= 2'h0;
         rec <= 0;
         wact <= 1'b0;
      end else begin
         if (rec < REC_CYC) rec <= rec + 1;
         if (rec == 0) sr <= 8'h80;
         if (busy == 1) begin
            mem[pa] <= pd;
            sr[7] <= 1'b1;
         end
         if (busy != 0) busy <= busy - 1;
         if (!we_n && !ce_n) begin
            wact <= 1'b1;
            wa <= addr[3:0];
            wdat <= dq_wr;
         end else if (wact) begin
            wact <= 1'b0;
            if (mode == 2'h2) begin
               mode <= 2'h1;
               if (!vpp_en) begin
                  sr <= sr | 8'h18;
               end else if (!wp_n && wa < 4'h2) begin
                  sr <= sr | 8'h12;
               end else begin
                  pa <= wa;
                  pd <= wdat;
                  busy <= BUSY_CYC;
                  sr[7] <= 1'b0;
               end
            end else if (wdat == PROG_CMD) mode <= 2'h2;
            else if (wdat == STAT_CMD) mode <= 2'h1;
            else if (wdat == READ_CMD) mode <= 2'h0;
         end
      end
   end
endmodule

`default_nettype wire

// [testbench/fpc_flash_host_tb.sv]
`default_nettype none

module fpc_flash_host_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [21:0] flash_addr;
   logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_powerdown_n;
   logic flash_wp_n, flash_vpp_en, flash_dq_oe_n;
   logic [15:0] flash_dq_out;
   wire logic [15:0] dq_rd;
   wire logic [15:0] dq_bus;
   logic [31:0] rd;
   int fails = 0;
   int samples_checked = 0;

   // Shared data pins
   assign dq_bus = flash_dq_oe_n ? dq_rd : flash_dq_out;

   // Clock
   always #4 core_clk = ~core_clk;

   fpc_flash_host #(.PD_RECOVERY_CYCLES(2), .ACCESS_CYCLES(4)) fpc_flash_host_i (
      .core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .flash_addr,
      .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_powerdown_n, .flash_wp_n,
      .flash_vpp_en, .flash_dq_in(dq_bus), .flash_dq_out, .flash_dq_oe_n);

   fpc_flash_model fpc_flash_model_i (.clk(core_clk), .addr(flash_addr), .ce_n(flash_ce_n),
      .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_powerdown_n(flash_reset_powerdown_n),
      .wp_n(flash_wp_n), .vpp_en(flash_vpp_en), .dq_wr(dq_bus), .dq_rd(dq_rd));

   // ------------------------------
   // Bus and compare helpers
   // ------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge core_clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wait_idle();
      do begin
         bus(1'b0, fpc_pkg::OFS_STATUS, 32'h0000_0000);
      end while (rd[1:0] !== 2'b00);
   endtask

   task automatic go(input logic [2:0] op);
      bus(1'b1, fpc_pkg::OFS_GO, {29'h0000_0000, op});
      wait_idle();
   endtask

   task automatic sr_ready();
      do begin
         go(fpc_pkg::OP_STATUS);
      end while (rd[fpc_pkg::ST_SR_READY] !== 1'b1);
   endtask

   task automatic rdata(input logic [15:0] exp);
      bus(1'b0, fpc_pkg::OFS_RDATA, 32'h0000_0000);
      check(rd & 32'h0000_FFFF, {16'h0000, exp});
   endtask

   // Two-step program, then status and an array read of the same word
   task automatic attempt(input logic [31:0] ctl, input logic [31:0] a, input logic [15:0] d,
                          input logic [3:0] err, input logic [15:0] exp);
      bus(1'b1, fpc_pkg::OFS_CTRL, ctl);
      bus(1'b1, fpc_pkg::OFS_ADDR1, a);
      bus(1'b1, fpc_pkg::OFS_ADDR2, a);
      bus(1'b1, fpc_pkg::OFS_WDATA, {d, 16'h0040});
      go(fpc_pkg::OP_SEQ);
      sr_ready();
      check({28'h000_0000, rd[7:4]}, {28'h000_0000, err});
      go(fpc_pkg::OP_READ);
      rdata(exp);
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_boot();
      wait_idle();
      check(rd & 32'h0000_03FF, 32'h0000_0004);
      bus(1'b0, fpc_pkg::OFS_CTRL, 32'h0000_0000);
      check(rd & 32'h0000_0007, 32'h0000_0000);
      bus(1'b0, 5'h1C, 32'h0000_0000);
      check(rd, 32'h0000_0000);
   endtask

   task automatic t_read();
      bus(1'b1, fpc_pkg::OFS_ADDR1, 32'h0000_0003);
      go(fpc_pkg::OP_READ);
      rdata(16'h1003);
      bus(1'b1, fpc_pkg::OFS_WDATA, 32'h0000_0070);
      go(fpc_pkg::OP_CMD);
      go(fpc_pkg::OP_READ);
      rdata(16'h1003);
   endtask

   task automatic t_abort();
      bus(1'b1, fpc_pkg::OFS_CTRL, 32'h0000_0006);
      bus(1'b1, fpc_pkg::OFS_ADDR1, 32'h0000_0007);
      bus(1'b1, fpc_pkg::OFS_ADDR2, 32'h0000_0007);
      bus(1'b1, fpc_pkg::OFS_WDATA, 32'hBEEF_0040);
      go(fpc_pkg::OP_SEQ);
      bus(1'b1, fpc_pkg::OFS_CTRL, 32'h0000_0007);
      @(posedge core_clk);
      check({31'h0000_0000, flash_reset_powerdown_n}, 32'h0000_0000);
      bus(1'b1, fpc_pkg::OFS_GO, 32'h0000_0001);
      bus(1'b0, fpc_pkg::OFS_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_0201, 32'h0000_0201);
      bus(1'b1, fpc_pkg::OFS_CTRL, 32'h0000_0006);
      wait_idle();
      check(rd & 32'h0000_0204, 32'h0000_0004);
      go(fpc_pkg::OP_READ);
      rdata(16'h4110);
      bus(1'b1, fpc_pkg::OFS_WDATA, 32'h0000_0070);
      go(fpc_pkg::OP_CMD);
      go(fpc_pkg::OP_STATUS);
      check(rd & 32'h0000_00F8, 32'h0000_0008);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Hang guard, far beyond the few hundred cycles used
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      t_boot();
      t_read();
      attempt(32'h0000_0006, 32'h0000_0005, 16'hA5A5, 4'h0, 16'hA5A5);
      attempt(32'h0000_0002, 32'h0000_0006, 16'h1234, 4'h5, 16'h1006);
      attempt(32'h0000_0004, 32'h0000_0001, 16'h4321, 4'h7, 16'h1001);
      t_abort();
      finish_test();
   end
endmodule

bind fpc_flash_host fpc_flash_host_sva #(.PD_RECOVERY_CYCLES(PD_RECOVERY_CYCLES))
   fpc_flash_host_sva_i (.core_clk, .srst, .avs_address, .avs_read, .avs_readdata,
   .avs_waitrequest, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_powerdown_n,
   .flash_dq_oe_n);

`default_nettype wire
